// >>> logic/sar_adc_control.sv
// control logic of a successive-approximation converter with Avalon-MM registers
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
module sar_adc_control
	import sar_adc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic [19:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire logic cmp_ge_in,
	input wire logic hw_trigger_in,
	output logic [11:0] trial_code_out,
	output logic sample_out,
	output logic comparator_power_out,
	output logic [4:0] channel_out,
	output logic ext_pos_reference_out,
	output logic [1:0] pos_ref_src_out,
	output logic ext_neg_reference_out,
	output logic conversion_end_irq_out
);

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_STAB = 5'h02,
		ST_SAMPLE = 5'h04,
		ST_COMPARE = 5'h08,
		ST_DONE = 5'h10
	} state_t;

	state_t state_q;
	logic wait_q, wr_take, adc_rst, stab_done, early_start_q;
	logic cmp_s1_q, cmp_s2_q, trg_s1_q, trg_s2_q, trg_s3_q, trg_edge;
	logic start_auto_set, start_auto_clr, all_done, in_limit;
	logic sample_q, irq_q, pos_ext_q, neg_ext_q;
	logic [31:0] readdata_q, rd_val;
	logic [7:0] wbyte, per_q, lim_up_q, lim_lo_q, test_q, result_upper_reg;
	mode_ctrl_t ctrl_q;
	mode_trig_t trig_q;
	mode_extra_t extra_q;
	channel_t chan_q;
	logic [11:0] result_wide_reg, approximation_register;
	logic [4:0] cnt_q, stab_cnt_q, stab_need, sample_len, chan_out_q;
	logic [3:0] bit_idx_q, stop_idx;
	logic [1:0] scan_idx_q, pos_src_q;

	assign readdata_out = readdata_q;
	assign waitrequest_out = wait_q;
	assign trial_code_out = approximation_register;
	assign sample_out = sample_q;
	assign comparator_power_out = ctrl_q.comparator_enable_bit;
	assign channel_out = chan_out_q;
	assign ext_pos_reference_out = pos_ext_q;
	assign pos_ref_src_out = pos_src_q;
	assign ext_neg_reference_out = neg_ext_q;
	assign conversion_end_irq_out = irq_q;

	// converter domain held in reset while its clock gate is off
	assign adc_rst = srst_in | ~per_q[PER_GATE_BIT];
	assign wr_take = write_in & ~wait_q & byteenable_in[0];
	assign wbyte = writedata_in[7:0];

	// pin inputs pass two flops before use
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			trg_s1_q <= 1'b0;
			trg_s2_q <= 1'b0;
			trg_s3_q <= 1'b0;
		end else begin
			cmp_s1_q <= cmp_ge_in;
			cmp_s2_q <= cmp_s1_q;
			trg_s1_q <= hw_trigger_in;
			trg_s2_q <= trg_s1_q;
			trg_s3_q <= trg_s2_q;
		end
	end
	assign trg_edge = trg_s2_q & ~trg_s3_q;

	// one wait cycle, then answer; read data registers on the edge that drops waitrequest, a write lands one edge later
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			wait_q <= 1'b1;
			readdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~((read_in | write_in) & wait_q);
			if (read_in & wait_q) begin
				readdata_q <= rd_val;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (address_in)
			OFF_PER_CLK_EN: rd_val[7:0] = per_q;
			OFF_MODE_CTRL: rd_val[7:0] = ctrl_q;
			OFF_MODE_TRIG: rd_val[7:0] = trig_q;
			OFF_MODE_EXTRA: rd_val[7:0] = extra_q;
			OFF_RESULT_WIDE: rd_val[11:0] = result_wide_reg;
			OFF_RESULT_UPPER: rd_val[7:0] = result_upper_reg;
			OFF_CHANNEL: rd_val[7:0] = chan_q;
			OFF_LIMIT_UPPER: rd_val[7:0] = lim_up_q;
			OFF_LIMIT_LOWER: rd_val[7:0] = lim_lo_q;
			OFF_TEST: rd_val[7:0] = test_q;
			OFF_STATUS: rd_val[3:0] = {early_start_q, stab_done,
				~state_q[0], ~adc_rst};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// clock-enable register lives outside the gated domain
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			per_q <= RST_PER_CLK_EN;
		end else if (wr_take && address_in == OFF_PER_CLK_EN) begin
			// unused bits read zero whatever software writes
			per_q <= wbyte & PER_WRITABLE;
		end
	end

	// configuration registers, all reset (upper limit to FF, the rest cleared) and locked while gated
	always_ff @(posedge clk_sys_in) begin
		if (adc_rst) begin
			trig_q <= RST_MODE;
			extra_q <= RST_MODE;
			chan_q <= RST_CHANNEL;
			lim_up_q <= RST_LIMIT_UPPER;
			lim_lo_q <= RST_LIMIT_LOWER;
			test_q <= RST_TEST;
		end else if (wr_take) begin
			case (address_in)
				OFF_MODE_TRIG: trig_q <= {wbyte[7:5], 5'h00};
				OFF_MODE_EXTRA: extra_q <= {wbyte[7:5], 4'h0, wbyte[0]};
				OFF_CHANNEL: chan_q <= {wbyte[7], 2'h0, wbyte[4:0]};
				OFF_LIMIT_UPPER: lim_up_q <= wbyte;
				OFF_LIMIT_LOWER: lim_lo_q <= wbyte;
				OFF_TEST: test_q <= wbyte & 8'h02;
				default: ;
			endcase
		end
	end

	// control register; hardware set wins over a software clear
	always_ff @(posedge clk_sys_in) begin
		if (adc_rst) begin
			ctrl_q <= RST_MODE;
		end else begin
			if (wr_take && address_in == OFF_MODE_CTRL) begin
				ctrl_q <= wbyte & MODE_CTRL_WRITABLE;
				// wait mode: only the trigger may set the start bit
				if (trig_q.trig_mode == TRIG_HW_WAIT) begin
					ctrl_q.conversion_start_bit <= wbyte[7] &
						ctrl_q.conversion_start_bit;
				end
			end else if (start_auto_clr) begin
				ctrl_q.conversion_start_bit <= 1'b0;
			end
			if (start_auto_set) begin
				ctrl_q.conversion_start_bit <= 1'b1;
			end
		end
	end

	// stabilization tracking from comparator enable
	always_comb begin
		if (test_q[TEST_MODE_BIT]) begin
			stab_need = 5'(STAB_SHORT_CYC);
		end else if (chan_q.internal_source_select ||
			chan_q.chan == 5'(CHAN_STD_CODE)) begin
			stab_need = 5'(STAB_LONG_CYC);
		end else begin
			stab_need = 5'(STAB_SHORT_CYC);
		end
	end
	assign stab_done = stab_cnt_q >= stab_need;

	always_ff @(posedge clk_sys_in) begin
		if (adc_rst || !ctrl_q.comparator_enable_bit) begin
			stab_cnt_q <= 5'h00;
		end else if (!stab_done) begin
			stab_cnt_q <= stab_cnt_q + 5'h01;
		end
	end

	// flag a software start made before the comparator settled
	always_ff @(posedge clk_sys_in) begin
		if (adc_rst) begin
			early_start_q <= 1'b0;
		end else if (state_q == ST_IDLE && ctrl_q.conversion_start_bit &&
			trig_q.trig_mode != TRIG_HW_WAIT) begin
			early_start_q <= ~stab_done;
		end
	end

	// reference selection drives the analog mux
	always_ff @(posedge clk_sys_in) begin
		if (adc_rst) begin
			pos_ext_q <= 1'b0;
			pos_src_q <= 2'h0;
			neg_ext_q <= 1'b0;
		end else begin
			pos_ext_q <= extra_q.pos_ref_sel_hi & extra_q.pos_ref_sel_lo;
			pos_src_q <= {extra_q.pos_ref_sel_hi, extra_q.pos_ref_sel_lo};
			neg_ext_q <= extra_q.neg_ref_sel;
		end
	end

	assign stop_idx = extra_q.res_8bit ? 4'h4 : 4'h0;
	assign sample_len = ctrl_q.conv_time_mode ? 5'(SAMPLE_NORMAL2_CYC) :
		5'(SAMPLE_NORMAL1_CYC);
	assign all_done = ~ctrl_q.channel_mode_bit ||
		scan_idx_q == 2'(SCAN_CHANNELS - 1);
	assign in_limit = approximation_register[11:4] <= lim_up_q &&
		approximation_register[11:4] >= lim_lo_q;
	assign start_auto_set = state_q == ST_IDLE &&
		trig_q.trig_mode == TRIG_HW_WAIT &&
		ctrl_q.comparator_enable_bit && trg_edge;
	// no-wait one-shot keeps the start bit and waits for the next trigger
	assign start_auto_clr = state_q == ST_DONE && all_done &&
		trig_q.one_shot && trig_q.trig_mode != TRIG_HW_NOWAIT;

	// conversion sequencer
	always_ff @(posedge clk_sys_in) begin
		if (adc_rst) begin
			state_q <= ST_IDLE;
			approximation_register <= 12'h000;
			bit_idx_q <= 4'hB;
			cnt_q <= 5'h00;
			scan_idx_q <= 2'h0;
			sample_q <= 1'b0;
			irq_q <= 1'b0;
			result_wide_reg <= 12'h000;
			result_upper_reg <= 8'h00;
			chan_out_q <= 5'h00;
		end else begin
			irq_q <= 1'b0;
			chan_out_q <= ctrl_q.channel_mode_bit ?
				chan_q.chan + {3'h0, scan_idx_q} : chan_q.chan;
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 5'h00;
					scan_idx_q <= 2'h0;
					approximation_register <= 12'h000;
					if (start_auto_set) begin
						state_q <= ST_STAB;
					end else if (ctrl_q.conversion_start_bit &&
						ctrl_q.comparator_enable_bit &&
						(trig_q.trig_mode == TRIG_SOFTWARE ||
						(trig_q.trig_mode == TRIG_HW_NOWAIT && trg_edge))) begin
						state_q <= ST_SAMPLE;
						sample_q <= 1'b1;
					end
				end
				ST_STAB: begin
					// start bit reads one through this wait as well
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q + 5'h01 >= stab_need) begin
						cnt_q <= 5'h00;
						state_q <= ST_SAMPLE;
						sample_q <= 1'b1;
					end
				end
				ST_SAMPLE: begin
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q + 5'h01 >= sample_len) begin
						cnt_q <= 5'h00;
						sample_q <= 1'b0;
						bit_idx_q <= 4'hB;
						approximation_register <= 12'h800;
						state_q <= ST_COMPARE;
					end
				end
				ST_COMPARE: begin
					// settle covers the two-flop comparator path
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'(CMP_SETTLE_CYC - 1)) begin
						cnt_q <= 5'h00;
						approximation_register[bit_idx_q] <= cmp_s2_q;
						if (bit_idx_q == stop_idx) begin
							state_q <= ST_DONE;
						end else begin
							bit_idx_q <= bit_idx_q - 4'h1;
							approximation_register[bit_idx_q - 4'h1] <= 1'b1;
						end
					end
				end
				ST_DONE: begin
					result_wide_reg <= approximation_register;
					result_upper_reg <= approximation_register[11:4];
					irq_q <= all_done & in_limit;
					scan_idx_q <= scan_idx_q + 2'h1;
					if (all_done && trig_q.one_shot) begin
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_SAMPLE;
						sample_q <= 1'b1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			// software stop aborts at any point
			if (!ctrl_q.conversion_start_bit && state_q != ST_IDLE &&
				!(state_q == ST_DONE && start_auto_clr)) begin
				state_q <= ST_IDLE;
				sample_q <= 1'b0;
			end
		end
	end

endmodule

// >>> include/sar_adc_pkg.sv
// shared constants and types for the successive-approximation converter control
package sar_adc_pkg;

	localparam int ADDR_W = 20;
	localparam int RES_W = 12;

	// register byte addresses
	localparam logic [19:0] OFF_PER_CLK_EN = 20'hF00F0;
	localparam logic [19:0] OFF_MODE_CTRL = 20'hFFF30;
	localparam logic [19:0] OFF_MODE_TRIG = 20'hFFF34;
	localparam logic [19:0] OFF_MODE_EXTRA = 20'hFFF38;
	localparam logic [19:0] OFF_RESULT_WIDE = 20'hFFF3C;
	localparam logic [19:0] OFF_RESULT_UPPER = 20'hFFF40;
	localparam logic [19:0] OFF_CHANNEL = 20'hFFF44;
	localparam logic [19:0] OFF_LIMIT_UPPER = 20'hFFF48;
	localparam logic [19:0] OFF_LIMIT_LOWER = 20'hFFF4C;
	localparam logic [19:0] OFF_TEST = 20'hFFF50;
	localparam logic [19:0] OFF_STATUS = 20'hFFF54;

	// field positions
	localparam int PER_GATE_BIT = 5;
	localparam logic [7:0] PER_WRITABLE = 8'h75;
	localparam logic [7:0] MODE_CTRL_WRITABLE = 8'hFD;
	localparam int CHAN_STD_CODE = 16;
	localparam int TEST_MODE_BIT = 1;

	// reset values
	localparam logic [7:0] RST_PER_CLK_EN = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CHANNEL = 8'h00;
	localparam logic [7:0] RST_LIMIT_UPPER = 8'hFF;
	localparam logic [7:0] RST_LIMIT_LOWER = 8'h00;
	localparam logic [7:0] RST_TEST = 8'h00;

	// timing
	localparam int CLK_NS = 100;
	localparam int STAB_SHORT_NS = 500;
	localparam int STAB_LONG_NS = 2000;
	localparam int STAB_SHORT_CYC = (STAB_SHORT_NS + CLK_NS - 1) / CLK_NS;
	localparam int STAB_LONG_CYC = (STAB_LONG_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_NORMAL1_CYC = 11;
	localparam int SAMPLE_NORMAL2_CYC = 23;
	localparam int CMP_SETTLE_CYC = 4;
	localparam int SCAN_CHANNELS = 4;

	// trigger modes in the trigger-mode register
	typedef enum logic [1:0] {
		TRIG_SOFTWARE = 2'h0,
		TRIG_HW_NOWAIT = 2'h2,
		TRIG_HW_WAIT = 2'h3
	} trig_mode_t;

	typedef struct packed {
		logic conversion_start_bit;
		logic channel_mode_bit;
		logic conv_clock_sel_2;
		logic conv_clock_sel_1;
		logic conv_clock_sel_0;
		logic conv_time_mode;
		logic reserved;
		logic comparator_enable_bit;
	} mode_ctrl_t;

	typedef struct packed {
		logic [1:0] trig_mode;
		logic one_shot;
		logic [4:0] reserved;
	} mode_trig_t;

	typedef struct packed {
		logic pos_ref_sel_hi;
		logic pos_ref_sel_lo;
		logic neg_ref_sel;
		logic [3:0] reserved;
		logic res_8bit;
	} mode_extra_t;

	typedef struct packed {
		logic internal_source_select;
		logic [1:0] reserved;
		logic [4:0] chan;
	} channel_t;

endpackage

// >>> test/sar_adc_control_sva.sv
// port checker for the converter control block
`timescale 1ns/1ns
module sar_adc_control_sva (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] readdata_out,
	input wire logic waitrequest_out,
	input wire logic [11:0] trial_code_out,
	input wire logic sample_out,
	input wire logic comparator_power_out,
	input wire logic ext_pos_reference_out,
	input wire logic [1:0] pos_ref_src_out,
	input wire logic conversion_end_irq_out
);
	logic [4:0] cnt_q;
	logic wr_q;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	sequence taken;
		(read_in || write_in) && waitrequest_out;
	endsequence
	sequence answered;
		!waitrequest_out ##1 waitrequest_out;
	endsequence
	// counter wraps if sampling hangs; the bound fires first
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !sample_out) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		wr_q <= !srst_in && write_in && !waitrequest_out;
	end
	a_wait_answer: assert property (taken |=> answered)
		else $error("request not answered in one cycle");
	a_wait_pulse: assert property (!waitrequest_out |=> waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_read_hold: assert property ($changed(readdata_out) |-> !waitrequest_out)
		else $error("read data changed outside an answer");
	a_upper_zero: assert property (readdata_out[31:12] == 20'h00000)
		else $error("read data upper bits not zero");
	a_msb_first: assert property (
		$fell(sample_out) && comparator_power_out |->
		trial_code_out == 12'h800)
		else $error("first trial is not the top bit");
	a_pos_ref: assert property (
		ext_pos_reference_out == (pos_ref_src_out == 2'h3))
		else $error("external positive reference select wrong");
	a_irq_pulse: assert property (
		conversion_end_irq_out |=> !conversion_end_irq_out)
		else $error("end interrupt longer than one cycle");
	a_sample_bound: assert property (sample_out |-> cnt_q < 5'h17)
		else $error("sampling longer than 23 cycles");
	a_power_write: assert property ($rose(comparator_power_out) |->
		wr_q || $past(wr_q))
		else $error("comparator powered without a write");
endmodule
bind sar_adc_control sar_adc_control_sva chk (.clk_sys_in, .srst_in,
	.read_in, .write_in, .readdata_out, .waitrequest_out, .trial_code_out,
	.sample_out, .comparator_power_out, .ext_pos_reference_out,
	.pos_ref_src_out, .conversion_end_irq_out);

// >>> test/analog_front_end.sv
// behavioural sample-and-hold and comparator on the analog side
`timescale 1ns/1ns
module analog_front_end (
	input wire logic clk_sys_in,
	input wire logic slow_in,
	input wire logic [11:0] level_in,
	input wire logic [11:0] trial_code_in,
	input wire logic sample_in,
	input wire logic power_in,
	input wire logic [4:0] channel_in,
	output logic cmp_ge_out
);
	logic [11:0] held_q = 12'h000;
	logic late_q = 1'b0;
	logic junk_q = 1'b0;
	logic fast;
	// channel shifts the level so scan results differ
	always_ff @(posedge clk_sys_in) begin
		if (sample_in) begin
			held_q <= level_in + {channel_in[3:0], 8'h00};
		end
		late_q <= fast;
		junk_q <= !junk_q;
	end
	assign fast = held_q >= trial_code_in;
	// unpowered comparator gives no usable answer
	assign cmp_ge_out = !power_in ? junk_q : (slow_in ? late_q : fast);
endmodule

// >>> test/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch at %0t: %0h vs %0h", $time, (a), (e)); end end
module tb
	import sar_adc_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic [19:0] address_in = 20'h00000;
	logic read_in = 1'b0;
	logic write_in = 1'b0;
	logic [31:0] writedata_in = 32'h00000000;
	logic [3:0] byteenable_in = 4'hF;
	logic hw_trigger_in = 1'b0;
	logic slow = 1'b0;
	logic [11:0] level = 12'h000;
	logic [31:0] readdata_out;
	logic [11:0] trial_code_out;
	logic [4:0] channel_out;
	logic [1:0] pos_ref_src_out;
	logic waitrequest_out, cmp_ge_in, sample_out, comparator_power_out;
	logic ext_pos_reference_out, ext_neg_reference_out, conversion_end_irq_out;
	logic [31:0] q;
	int num_errors = 0;
	int check_count = 0;
	int run_len = 0;
	int last_len = 0;
	int irqs = 0;
	logic [4:0] chans[$];
	always #50 clk_sys_in = ~clk_sys_in;
	sar_adc_control dut (.*);
	analog_front_end afe (.clk_sys_in, .slow_in(slow), .level_in(level),
		.trial_code_in(trial_code_out), .sample_in(sample_out),
		.power_in(comparator_power_out), .channel_in(channel_out),
		.cmp_ge_out(cmp_ge_in));
	always @(posedge clk_sys_in) begin
		if (sample_out === 1'b1) begin
			run_len++;
			if (run_len == 5) chans.push_back(channel_out);
		end else if (run_len != 0) begin
			last_len = run_len;
			run_len = 0;
		end
		if (conversion_end_irq_out === 1'b1) irqs++;
	end
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [19:0] a,
		input logic [7:0] d);
		@(posedge clk_sys_in);
		address_in <= a;
		writedata_in <= {24'h000000, d};
		write_in <= wr;
		read_in <= !wr;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk_sys_in);
		end while (waitrequest_out !== 1'b0);
		q = readdata_out;
		write_in <= 1'b0;
		read_in <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		`CHK(q, e)
	endtask
	// mode fields change only while stopped and powered down
	task automatic go(input logic [7:0] m, input logic [11:0] v);
		level <= v;
		bus(1'b1, OFF_MODE_CTRL, m & 8'h7E);
		bus(1'b1, OFF_MODE_CTRL, m & 8'h7F);
		repeat (22) @(posedge clk_sys_in);
		bus(1'b0, OFF_STATUS, 8'h00);
		`CHK(q[2], 1'b1)
		bus(1'b1, OFF_MODE_CTRL, m);
	endtask
	task automatic wait_irq(input int e, input int lim);
		int n;
		n = 0;
		irqs = 0;
		while (n < lim && (e == 0 || irqs < e)) begin
			@(posedge clk_sys_in);
			n++;
		end
		`CHK(irqs, e)
	endtask
	task automatic pulse;
		hw_trigger_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		hw_trigger_in <= 1'b0;
	endtask
	initial begin
		#2000000;
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rd(OFF_PER_CLK_EN, 32'h00000000);
		rd(OFF_LIMIT_UPPER, 32'h000000FF);
		bus(1'b1, OFF_MODE_CTRL, 8'h01);
		rd(OFF_MODE_CTRL, 32'h00000000);
		bus(1'b1, OFF_PER_CLK_EN, 8'h20);
		rd(OFF_PER_CLK_EN, 32'h00000020);
		byteenable_in <= 4'h0;
		bus(1'b1, OFF_LIMIT_LOWER, 8'h55);
		byteenable_in <= 4'hF;
		rd(OFF_LIMIT_LOWER, 32'h00000000);
		rd(20'hFFF60, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, OFF_MODE_EXTRA, {i[2:0], 5'h00});
			repeat (3) @(posedge clk_sys_in);
			`CHK(pos_ref_src_out, i[2:1])
			`CHK(ext_pos_reference_out, &i[2:1])
			`CHK(ext_neg_reference_out, i[0])
		end
		bus(1'b1, OFF_MODE_EXTRA, 8'h00);
		bus(1'b1, OFF_MODE_TRIG, 8'h20);
		go(8'h81, 12'hA5C);
		wait_irq(1, 900);
		`CHK(last_len, 11)
		rd(OFF_RESULT_WIDE, 32'h00000A5C);
		rd(OFF_RESULT_UPPER, 32'h000000A5);
		rd(OFF_MODE_CTRL, 32'h00000001);
		bus(1'b1, OFF_LIMIT_LOWER, 8'hB0);
		slow <= 1'b1;
		go(8'h81, 12'hA5C);
		wait_irq(0, 150);
		rd(OFF_RESULT_UPPER, 32'h000000A5);
		go(8'h81, 12'hC30);
		wait_irq(1, 900);
		rd(OFF_RESULT_WIDE, 32'h00000C30);
		bus(1'b1, OFF_LIMIT_LOWER, 8'h00);
		slow <= 1'b0;
		go(8'h85, 12'h001);
		wait_irq(1, 900);
		`CHK(last_len, 23)
		rd(OFF_RESULT_WIDE, 32'h00000001);
		bus(1'b1, OFF_MODE_EXTRA, 8'h01);
		go(8'h81, 12'h7FF);
		wait_irq(1, 900);
		rd(OFF_RESULT_WIDE, 32'h000007F0);
		rd(OFF_RESULT_UPPER, 32'h0000007F);
		bus(1'b1, OFF_MODE_EXTRA, 8'h00);
		bus(1'b1, OFF_MODE_CTRL, 8'h00);
		bus(1'b1, OFF_CHANNEL, 8'h90);
		bus(1'b1, OFF_MODE_CTRL, 8'h01);
		repeat (6) @(posedge clk_sys_in);
		rd(OFF_STATUS, 32'h00000001);
		bus(1'b1, OFF_TEST, 8'h02);
		rd(OFF_STATUS, 32'h00000005);
		bus(1'b1, OFF_TEST, 8'h00);
		bus(1'b1, OFF_CHANNEL, 8'h02);
		chans.delete();
		go(8'hC1, 12'h123);
		wait_irq(1, 900);
		`CHK(chans.size(), 4)
		for (int k = 0; k < 4; k++) `CHK(chans[k], 5'(k + 2))
		rd(OFF_RESULT_WIDE, 32'h00000623);
		bus(1'b1, OFF_CHANNEL, 8'h00);
		bus(1'b1, OFF_MODE_TRIG, 8'h00);
		go(8'h81, 12'h456);
		wait_irq(2, 900);
		rd(OFF_MODE_CTRL, 32'h00000081);
		bus(1'b1, OFF_MODE_TRIG, 8'hE0);
		go(8'h81, 12'h3C3);
		rd(OFF_MODE_CTRL, 32'h00000001);
		pulse();
		rd(OFF_MODE_CTRL, 32'h00000081);
		wait_irq(1, 900);
		rd(OFF_MODE_CTRL, 32'h00000001);
		bus(1'b1, OFF_MODE_TRIG, 8'hA0);
		go(8'h81, 12'h3C3);
		pulse();
		wait_irq(1, 900);
		rd(OFF_MODE_CTRL, 32'h00000081);
		rd(OFF_RESULT_WIDE, 32'h000003C3);
		bus(1'b1, OFF_PER_CLK_EN, 8'h00);
		rd(OFF_MODE_CTRL, 32'h00000000);
		rd(OFF_RESULT_WIDE, 32'h00000000);
		rd(OFF_MODE_TRIG, 32'h00000000);
		stop_test;
	end
endmodule
